// File: lvd_ctrl_pkg.sv
// Package: register map, field positions and types for the low-voltage detect control block
package lvd_ctrl_pkg;

    // ==========================================
    // Register map
    localparam logic [15:0] LVSC_ADDR     = 16'h3040;
    localparam logic [7:0]  LVSC_RESET    = 8'h1C;

    // ==========================================
    // Field positions
    localparam int          WARN_FLAG_BIT     = 7;
    localparam int          WARN_ACK_BIT      = 6;
    localparam int          WARN_IRQ_EN_BIT   = 5;
    localparam int          DETECT_RESET_BIT  = 4;
    localparam int          DETECT_STOP_BIT   = 3;
    localparam int          DETECT_EN_BIT     = 2;
    localparam int          BG_DRIVE_BIT      = 1;
    localparam int          BG_BUF_EN_BIT     = 0;

    // ==========================================
    // Bus answer
    localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

    typedef struct packed {
        logic       warn_flag;
        logic       warn_irq_en;
        logic       detect_reset_en;
        logic       detect_stop_en;
        logic       detect_en;
        logic       bandgap_drive_sel;
        logic       bandgap_buf_en;
        logic       once_written;
    } ctrl_t;

    typedef struct packed {
        logic       irq;
        logic       chip_reset_req;
        logic       detect_active;
        logic       bg_buf_en;
        logic       bg_high_drive;
    } pmc_out_t;

    typedef struct packed {
        ctrl_t      ctrl;
        pmc_out_t   outs;
        logic [31:0] prdata;
        logic       pready;
        logic       pslverr;
    } state_t;

endpackage

// File: low_voltage_detect_control.sv
// Low-voltage detect control and status register with APB slave
`timescale 1ns/1ps

module low_voltage_detect_control
    import lvd_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog comparators and mode
    input  wire logic        warn_cond,
    input  wire logic        detect_cond,
    input  wire logic        stop_mode,
    // Control outputs
    output logic             warn_irq,
    output logic             chip_reset_req,
    output logic             detect_active,
    output logic             bandgap_buf_en,
    output logic             bandgap_high_drive
);

    state_t state;
    state_t next_state;

    // ==========================================
    // Decode helpers
    function automatic logic hit(input logic [15:0] a);
        hit = (a == LVSC_ADDR);
    endfunction

    function automatic logic [7:0] read_view(input ctrl_t c);
        logic [7:0] v;
        v = 8'h00;
        v[WARN_FLAG_BIT]    = c.warn_flag;
        v[WARN_IRQ_EN_BIT]  = c.warn_irq_en;
        v[DETECT_RESET_BIT] = c.detect_reset_en;
        v[DETECT_STOP_BIT]  = c.detect_stop_en;
        v[DETECT_EN_BIT]    = c.detect_en;
        v[BG_DRIVE_BIT]     = c.bandgap_drive_sel;
        v[BG_BUF_EN_BIT]    = c.bandgap_buf_en;
        read_view = v;
    endfunction

    logic setup_ph;
    logic wr_acc;
    logic det_live;
    assign setup_ph = psel & ~penable;
    // Write lands at the access edge, when pready is high
    assign wr_acc   = psel & penable & pready & pwrite & hit(paddr);
    // Detect logic runs only when enabled, and in stop only with stop enable
    assign det_live = state.ctrl.detect_en & (~stop_mode | state.ctrl.detect_stop_en);

    // ==========================================
    // Next-state logic
    always_comb begin
        next_state = state;
        next_state.pready  = 1'b0;
        next_state.pslverr = 1'b0;
        // No wait state: answer in the cycle after setup
        if (setup_ph) begin
            next_state.pready  = 1'b1;
            next_state.pslverr = ~hit(paddr);
            next_state.prdata  = (!pwrite && hit(paddr))
                               ? {24'h000000, read_view(state.ctrl)} : RDATA_ZERO;
        end
        if (wr_acc) begin
            next_state.ctrl.detect_stop_en    = pwdata[DETECT_STOP_BIT];
            next_state.ctrl.bandgap_buf_en    = pwdata[BG_BUF_EN_BIT];
            next_state.ctrl.bandgap_drive_sel = pwdata[BG_DRIVE_BIT];
            next_state.ctrl.warn_irq_en       = pwdata[WARN_IRQ_EN_BIT];
            if (!state.ctrl.once_written) begin
                next_state.ctrl.detect_reset_en = pwdata[DETECT_RESET_BIT];
                next_state.ctrl.detect_en       = pwdata[DETECT_EN_BIT];
                next_state.ctrl.once_written    = 1'b1;
            end
            // ack clears only with condition gone
            if (pwdata[WARN_ACK_BIT] && !warn_cond) begin
                next_state.ctrl.warn_flag = 1'b0;
            end
        end
        if (warn_cond && state.ctrl.detect_en) begin
            next_state.ctrl.warn_flag = 1'b1;
        end
        next_state.outs.irq            = next_state.ctrl.warn_flag & next_state.ctrl.warn_irq_en;
        // reset on detect with detector live and reset enable on
        next_state.outs.chip_reset_req = det_live & detect_cond & state.ctrl.detect_reset_en;
        next_state.outs.detect_active  = next_state.ctrl.detect_en
                                       & (~stop_mode | next_state.ctrl.detect_stop_en);
        next_state.outs.bg_buf_en      = next_state.ctrl.bandgap_buf_en;
        next_state.outs.bg_high_drive  = next_state.ctrl.bandgap_buf_en
                                       & next_state.ctrl.bandgap_drive_sel;
    end

    // ==========================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                        <= '0;
            state.ctrl.detect_reset_en   <= LVSC_RESET[DETECT_RESET_BIT];
            state.ctrl.detect_stop_en    <= LVSC_RESET[DETECT_STOP_BIT];
            state.ctrl.detect_en         <= LVSC_RESET[DETECT_EN_BIT];
            state.outs.detect_active     <= LVSC_RESET[DETECT_EN_BIT];
        end else begin
            state <= next_state;
        end
    end

    assign prdata             = state.prdata;
    assign pready             = state.pready;
    assign pslverr            = state.pslverr;
    assign warn_irq           = state.outs.irq;
    assign chip_reset_req     = state.outs.chip_reset_req;
    assign detect_active      = state.outs.detect_active;
    assign bandgap_buf_en     = state.outs.bg_buf_en;
    assign bandgap_high_drive = state.outs.bg_high_drive;

    // ==========================================
    // Assertions
    // flag sticky without ack
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        state.ctrl.warn_flag && !(wr_acc && pwdata[WARN_ACK_BIT])
        |=> state.ctrl.warn_flag)
        else $error("warning flag dropped without acknowledge");

    a_flag_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !state.ctrl.warn_flag && !(warn_cond && state.ctrl.detect_en)
        |=> !state.ctrl.warn_flag)
        else $error("warning flag set without condition");

    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        warn_cond && state.ctrl.detect_en
        |=> state.ctrl.warn_flag)
        else $error("warning flag not set by condition");

    a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && pwdata[WARN_ACK_BIT] && !warn_cond
        |=> !state.ctrl.warn_flag)
        else $error("acknowledge did not clear flag");

    a_ack_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        state.ctrl.warn_flag && warn_cond
        |=> state.ctrl.warn_flag)
        else $error("flag cleared while warning present");

    a_ack_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready
        |-> !prdata[WARN_ACK_BIT])
        else $error("acknowledge bit read as one");

    a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
        warn_irq == (state.ctrl.warn_flag && state.ctrl.warn_irq_en))
        else $error("interrupt mismatch");

    a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !state.ctrl.warn_irq_en
        |-> !warn_irq)
        else $error("interrupt raised while disabled");

    a_reset_gate: assert property (@(posedge pclk) disable iff (!presetn)
        chip_reset_req
        |-> $past(state.ctrl.detect_reset_en && state.ctrl.detect_en))
        else $error("reset without enables");

    a_reset_fires: assert property (@(posedge pclk) disable iff (!presetn)
        detect_cond && state.ctrl.detect_en && state.ctrl.detect_reset_en
        && (!stop_mode || state.ctrl.detect_stop_en) |=> chip_reset_req)
        else $error("detect event gave no reset request");

    a_reset_off: assert property (@(posedge pclk) disable iff (!presetn)
        !state.ctrl.detect_reset_en
        |=> !chip_reset_req)
        else $error("reset request with reset enable clear");

    a_stop_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc
        |=> state.ctrl.detect_stop_en == $past(pwdata[DETECT_STOP_BIT]))
        else $error("stop enable not written");

    a_stop_gate: assert property (@(posedge pclk) disable iff (!presetn)
        $past(stop_mode) && !state.ctrl.detect_stop_en
        |-> !detect_active)
        else $error("detect active in stop without stop enable");

    a_stop_live: assert property (@(posedge pclk) disable iff (!presetn)
        state.ctrl.detect_en && state.ctrl.detect_stop_en
        |-> detect_active)
        else $error("detect inactive with stop enable set");

    a_detect_gate: assert property (@(posedge pclk) disable iff (!presetn)
        detect_active
        |-> state.ctrl.detect_en)
        else $error("detect active while disabled");

    a_detect_off: assert property (@(posedge pclk) disable iff (!presetn)
        !state.ctrl.detect_en
        |=> !chip_reset_req)
        else $error("reset request with detector disabled");

    a_once_first: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && !state.ctrl.once_written
        |=> state.ctrl.detect_en == $past(pwdata[DETECT_EN_BIT]))
        else $error("first write did not set detector enable");

    a_buf_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc
        |=> bandgap_buf_en == $past(pwdata[BG_BUF_EN_BIT]))
        else $error("bandgap buffer enable not written");

    a_drive_gate: assert property (@(posedge pclk) disable iff (!presetn)
        bandgap_high_drive
        |-> bandgap_buf_en)
        else $error("high drive without buffer");

    a_drive_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc
        |=> bandgap_high_drive == $past(pwdata[BG_BUF_EN_BIT] && pwdata[BG_DRIVE_BIT]))
        else $error("drive select not written");

    a_once_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state.ctrl.once_written
        |=> $stable(state.ctrl.detect_en) && $stable(state.ctrl.detect_reset_en))
        else $error("write-once bit changed");

    a_once_marker: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc
        |=> state.ctrl.once_written)
        else $error("write marker not set");

    // One access cycle per transfer
    a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable
        |=> pready ##1 !pready)
        else $error("pready timing wrong");

    // Unmapped address answers with error
    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && (paddr != LVSC_ADDR)
        |=> pslverr)
        else $error("unmapped address gave no error");

    // ==========================================
    // Coverage of main scenarios
    c_ack_clear: cover property (@(posedge pclk) disable iff (!presetn)
        state.ctrl.warn_flag ##1 !state.ctrl.warn_flag);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn)
        warn_irq);
    c_reset: cover property (@(posedge pclk) disable iff (!presetn)
        chip_reset_req);
    c_second_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_acc && state.ctrl.once_written);
    c_stop_hold: cover property (@(posedge pclk) disable iff (!presetn)
        stop_mode && detect_active);

endmodule

// File: low_voltage_detect_control_tb_top.sv
// Directed testbench for the low-voltage detect control block
`timescale 1ns/1ps
module low_voltage_detect_control_tb_top
    import lvd_ctrl_pkg::*;
;
    // ==========================================
    // Signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        warn_cond;
    logic        detect_cond;
    logic        stop_mode;
    logic        warn_irq;
    logic        chip_reset_req;
    logic        detect_active;
    logic        bandgap_buf_en;
    logic        bandgap_high_drive;
    logic [31:0] rd;
    logic        err;
    int          err_count;
    int          check_count;
    int          cycles;

    low_voltage_detect_control u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .warn_cond(warn_cond), .detect_cond(detect_cond), .stop_mode(stop_mode),
        .warn_irq(warn_irq), .chip_reset_req(chip_reset_req), .detect_active(detect_active),
        .bandgap_buf_en(bandgap_buf_en), .bandgap_high_drive(bandgap_high_drive)
    );

    // ==========================================
    // Clock and hang guard
    always #5 pclk = ~pclk;

    // Generous ceiling: the directed run needs about a hundred cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end

    // ==========================================
    // Tasks
    task automatic results();
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_pin(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] addr, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, addr, 32'h0000_0000);
        chk("prdata", exp, rd);
        chk_pin("pslverr", exp_err, err);
    endtask

    // Outputs settle one cycle after their cause; two edges leave margin
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        #1;
        chk_pin("detect_active", 1'b1, detect_active);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        {pclk, psel, penable, pwrite, warn_cond, detect_cond, stop_mode} = 7'h00;
        {paddr, pwdata, err_count, check_count, cycles} = '0;
        // Starts high so the reset task makes a clean falling edge
        presetn = 1'b1;
        do_reset();
        rd_chk(LVSC_ADDR, 32'h0000_001C, 1'b0);
        rd_chk(16'h3041, RDATA_ZERO, 1'b1);
        warn_cond <= 1'b1;
        wait_n(3);
        rd_chk(LVSC_ADDR, 32'h0000_009C, 1'b0);
        apb(1'b1, LVSC_ADDR, 32'h0000_005C);
        warn_cond <= 1'b0;
        wait_n(3);
        rd_chk(LVSC_ADDR, 32'h0000_009C, 1'b0);
        apb(1'b1, LVSC_ADDR, 32'h0000_0043);
        rd_chk(LVSC_ADDR, 32'h0000_0017, 1'b0);
        chk_pin("bandgap_buf_en", 1'b1, bandgap_buf_en);
        chk_pin("bandgap_high_drive", 1'b1, bandgap_high_drive);
        stop_mode   <= 1'b1;
        detect_cond <= 1'b1;
        wait_n(3);
        chk_pin("detect_active", 1'b0, detect_active);
        chk_pin("chip_reset_req", 1'b0, chip_reset_req);
        apb(1'b1, LVSC_ADDR, 32'h0000_0019);
        wait_n(2);
        chk_pin("detect_active", 1'b1, detect_active);
        chk_pin("chip_reset_req", 1'b1, chip_reset_req);
        chk_pin("bandgap_high_drive", 1'b0, bandgap_high_drive);
        rd_chk(LVSC_ADDR, 32'h0000_001D, 1'b0);
        {stop_mode, detect_cond} <= 2'b00;
        apb(1'b1, LVSC_ADDR, 32'h0000_003C);
        wait_n(2);
        chk_pin("warn_irq", 1'b0, warn_irq);
        @(posedge pclk);
        warn_cond <= 1'b1;
        wait_n(3);
        chk_pin("warn_irq", 1'b1, warn_irq);
        apb(1'b1, LVSC_ADDR, 32'h0000_001C);
        warn_cond <= 1'b0;
        wait_n(2);
        chk_pin("warn_irq", 1'b0, warn_irq);
        // Second reset reopens the write-once bits
        @(posedge pclk);
        do_reset();
        apb(1'b1, LVSC_ADDR, 32'h0000_002C);
        apb(1'b1, LVSC_ADDR, 32'h0000_0014);
        rd_chk(LVSC_ADDR, 32'h0000_0004, 1'b0);
        detect_cond <= 1'b1;
        wait_n(3);
        chk_pin("chip_reset_req", 1'b0, chip_reset_req);
        // Supply already low when reset is released
        @(posedge pclk);
        warn_cond <= 1'b1;
        do_reset();
        wait_n(2);
        chk_pin("chip_reset_req", 1'b1, chip_reset_req);
        rd_chk(LVSC_ADDR, 32'h0000_009C, 1'b0);
        apb(1'b1, LVSC_ADDR, 32'h0000_0000);
        wait_n(2);
        chk_pin("detect_active", 1'b0, detect_active);
        chk_pin("chip_reset_req", 1'b0, chip_reset_req);
        rd_chk(LVSC_ADDR, 32'h0000_0080, 1'b0);
        results();
    end
endmodule
